// file: ptm_pkg.sv
// Purpose: shared constants and types for the 10-bit periodic timer
// Assumes: APB slave, 32-bit data, byte-wide registers in the low bits
// Notes: register offsets are byte addresses
package ptm_pkg;
    // ********************
    // register map
    // ********************
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0c;
    localparam logic [7:0] OFS_CMPA_LO = 8'h10;
    localparam logic [7:0] OFS_CMPA_HI = 8'h14;
    localparam logic [7:0] OFS_PER_LO = 8'h18;
    localparam logic [7:0] OFS_PER_HI = 8'h1c;
    localparam logic [7:0] OFS_FLAGS = 8'h20;
    // ********************
    // field positions
    // ********************
    localparam int C0_PAUSE = 7;
    localparam int C0_CK_HI = 6;
    localparam int C0_CK_LO = 4;
    localparam int C0_ON = 3;
    localparam int C1_MODE_HI = 7;
    localparam int C1_MODE_LO = 6;
    localparam int C1_FUNC_HI = 5;
    localparam int C1_FUNC_LO = 4;
    localparam int C1_INIT = 3;
    localparam int C1_INV = 2;
    localparam int C1_CLR = 0;
    localparam int FL_A = 0;
    localparam int FL_B = 1;
    localparam logic [7:0] C0_MASK = 8'hf8;
    localparam logic [7:0] C1_RESET = 8'h00;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [5:0] DIV64_LAST = 6'h3f;
    // ********************
    // enumerations
    // ********************
    typedef enum logic [1:0] {MODE_CMP = 2'h0, MODE_CAP = 2'h1, MODE_PWM = 2'h2,
        MODE_TMR = 2'h3} mode_t;
    typedef enum logic [1:0] {FN_NONE = 2'h0, FN_LOW = 2'h1, FN_HIGH = 2'h2,
        FN_TOGGLE = 2'h3} func_t;
    typedef enum logic [2:0] {CK_DIV4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2,
        CK_H64 = 3'h3, CK_SUB = 3'h4, CK_OFF = 3'h5, CK_EXT_RISE = 3'h6,
        CK_EXT_FALL = 3'h7} cksel_t;
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage

// file: periodic_timer.sv
// Purpose: 10-bit periodic timer, compare/timer/PWM modes, APB registers
// Assumes: pclk 200 MHz; sub clock and ext pin asynchronous
// Notes: capture and timer modes count only, pin unchanged
`timescale 1ns/1ps
// Contract
// - counter readable as two read-only bytes
// - two-bit mode field selects operating mode
// - mode 00 is compare match output
// - clear select low clears on B/overflow
// - clear select high clears on A only
// - compare mode pin changes only on A match or on rise
// - on rising sets pin to initial level
// - function 00 leaves pin unchanged
// - mode 11 counts without driving pin
// - PWM clears at count B-1 (period B), duty from A
// - B zero gives period 1024
// - PWM flags on A match and at count B-1
// - PWM polarity, enable, force and invert
// - A at or above period: full duty
// - PWM generation runs while pin forced
// - on rise zeroes counter, fall holds it
// - pause holds counter value
// - three-bit clock select, 101 disables
// - compare mode high, low or toggle
module periodic_timer
    import ptm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    input wire logic sub_clk_in,
    input wire logic timer_ext_clock_pin,
    output logic timer_out_pin,
    output logic timer_out_en,
    output logic match_a_irq,
    output logic match_b_irq
);
    // ********************
    // registers
    // ********************
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [9:0] cnt_q;
    logic [9:0] cmpa_q;
    logic [9:0] per_q;
    logic flag_a_q;
    logic flag_b_q;
    logic pin_q;
    logic on_prev_q;
    logic [1:0] div4_q;
    logic [5:0] divh_q;
    logic [2:0] ext_sync_q;
    logic [2:0] sub_sync_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic wr_en;
    logic rd_en;
    logic counter_on;
    logic counter_pause;
    cksel_t count_clock_select;
    mode_t mode_sel;
    func_t out_func;
    logic out_initial_level;
    logic out_invert;
    logic clear_select;
    logic tick;
    logic on_rise;
    logic match_a;
    logic match_b;
    logic clr_cnt;
    logic set_a;
    logic set_b;
    logic pwm_active;
    logic pwm_wave;
    logic [10:0] period;
    logic counting;
    logic pwm_end;
    logic pin_d;
    logic [31:0] prdata_d;

    // ********************
    // control decode
    // ********************
    assign counter_on = ctrl0_q[C0_ON];
    assign counter_pause = ctrl0_q[C0_PAUSE];
    assign count_clock_select = cksel_t'(ctrl0_q[C0_CK_HI:C0_CK_LO]);
    assign mode_sel = mode_t'(ctrl1_q[C1_MODE_HI:C1_MODE_LO]);
    assign out_func = func_t'(ctrl1_q[C1_FUNC_HI:C1_FUNC_LO]);
    assign out_initial_level = ctrl1_q[C1_INIT];
    assign out_invert = ctrl1_q[C1_INV];
    assign clear_select = ctrl1_q[C1_CLR];
    assign on_rise = counter_on & ~on_prev_q;
    // a restart zeroes the counter, so no match on the stale count
    assign counting = counter_on & ~on_rise & ~counter_pause & tick;

    // ********************
    // apb slave
    // ********************
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & pready_q;
    assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_q <= 1'b0;
        else
            pready_q <= apb_req.psel & ~apb_req.penable;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (rd_en)
            prdata_q <= prdata_d;
    end

    always_comb
    begin
        unique case (apb_req.paddr)
            OFS_CTRL0: prdata_d = {24'h000000, ctrl0_q};
            OFS_CTRL1: prdata_d = {24'h000000, ctrl1_q};
            OFS_CNT_LO: prdata_d = {24'h000000, cnt_q[7:0]};
            OFS_CNT_HI: prdata_d = {30'h0, cnt_q[9:8]};
            OFS_CMPA_LO: prdata_d = {24'h000000, cmpa_q[7:0]};
            OFS_CMPA_HI: prdata_d = {30'h0, cmpa_q[9:8]};
            OFS_PER_LO: prdata_d = {24'h000000, per_q[7:0]};
            OFS_PER_HI: prdata_d = {30'h0, per_q[9:8]};
            OFS_FLAGS: prdata_d = {30'h0, flag_b_q, flag_a_q};
            default: prdata_d = 32'h0000_0000;
        endcase
    end

    // ********************
    // register writes
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl0_q <= 8'h00;
        else if (wr_en && apb_req.paddr == OFS_CTRL0)
            ctrl0_q <= apb_req.pwdata[7:0] & C0_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl1_q <= C1_RESET;
        else if (wr_en && apb_req.paddr == OFS_CTRL1)
            ctrl1_q <= apb_req.pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmpa_q <= CNT_ZERO;
        else if (wr_en && apb_req.paddr == OFS_CMPA_LO)
            cmpa_q[7:0] <= apb_req.pwdata[7:0];
        else if (wr_en && apb_req.paddr == OFS_CMPA_HI)
            cmpa_q[9:8] <= apb_req.pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            per_q <= CNT_ZERO;
        else if (wr_en && apb_req.paddr == OFS_PER_LO)
            per_q[7:0] <= apb_req.pwdata[7:0];
        else if (wr_en && apb_req.paddr == OFS_PER_HI)
            per_q[9:8] <= apb_req.pwdata[1:0];
    end

    assign apb_rsp.prdata = prdata_q;
    assign apb_rsp.pready = pready_q;
    assign apb_rsp.pslverr = 1'b0;

    // ********************
    // counting clock
    // ********************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_sync_q <= 3'h0;
        else
            ext_sync_q <= {ext_sync_q[1:0], timer_ext_clock_pin};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sub_sync_q <= 3'h0;
        else
            sub_sync_q <= {sub_sync_q[1:0], sub_clk_in};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div4_q <= 2'h0;
        else
            div4_q <= div4_q + 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            divh_q <= 6'h00;
        else
            divh_q <= divh_q + 6'h01;
    end

    always_comb
    begin
        unique case (count_clock_select)
            CK_DIV4: tick = (div4_q == DIV4_LAST);
            CK_SYS: tick = 1'b1;
            CK_H16: tick = (divh_q[3:0] == DIV16_LAST);
            CK_H64: tick = (divh_q == DIV64_LAST);
            CK_SUB: tick = sub_sync_q[1] & ~sub_sync_q[2];
            CK_OFF: tick = 1'b0;
            CK_EXT_RISE: tick = ext_sync_q[1] & ~ext_sync_q[2];
            CK_EXT_FALL: tick = ~ext_sync_q[1] & ext_sync_q[2];
        endcase
    end

    // ********************
    // compare and clear
    // ********************
    assign period = (per_q == CNT_ZERO) ? {1'b1, CNT_ZERO} : {1'b0, per_q};
    assign match_a = (cnt_q == cmpa_q);
    assign match_b = (per_q == CNT_ZERO) ? (cnt_q == CNT_MAX) : (cnt_q == per_q);
    // pwm counts 0 to period-1, so the period equals compare b, or 1024 when b is zero
    assign pwm_end = ({1'b0, cnt_q} == (period - 11'h001));

    always_comb
    begin
        clr_cnt = 1'b0;
        set_a = 1'b0;
        set_b = 1'b0;
        if (counting)
        begin
            if (mode_sel == MODE_PWM)
            begin
                clr_cnt = pwm_end;
                set_a = match_a;
                set_b = pwm_end;
            end
            else if (clear_select)
            begin
                clr_cnt = match_a;
                set_a = match_a;
            end
            else
            begin
                clr_cnt = match_b;
                set_a = match_a;
                set_b = match_b;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            on_prev_q <= 1'b0;
        else
            on_prev_q <= counter_on;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= CNT_ZERO;
        else if (on_rise)
            cnt_q <= CNT_ZERO;
        else if (counting)
            cnt_q <= clr_cnt ? CNT_ZERO : cnt_q + 10'h001;
    end

    // ********************
    // match flags
    // ********************
    // sticky flags, set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_a_q <= 1'b0;
        else
            flag_a_q <= set_a | (flag_a_q & ~(wr_en && apb_req.paddr == OFS_FLAGS
                && apb_req.pwdata[FL_A]));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_b_q <= 1'b0;
        else
            flag_b_q <= set_b | (flag_b_q & ~(wr_en && apb_req.paddr == OFS_FLAGS
                && apb_req.pwdata[FL_B]));
    end

    assign match_a_irq = flag_a_q;
    assign match_b_irq = flag_b_q;

    // ********************
    // output pin
    // ********************
    assign pwm_active = ({1'b0, cnt_q} < {1'b0, cmpa_q}) || ({1'b0, cmpa_q} >= period);
    always_comb
    begin
        unique case (out_func)
            FN_NONE: pwm_wave = 1'b0;
            FN_LOW: pwm_wave = 1'b1;
            default: pwm_wave = pwm_active;
        endcase
    end

    always_comb
    begin
        pin_d = pin_q;
        if (mode_sel == MODE_PWM)
            pin_d = (out_initial_level ? pwm_wave : ~pwm_wave) ^ out_invert;
        else if (mode_sel == MODE_CMP)
        begin
            if (on_rise)
                pin_d = out_initial_level;
            else if (set_a)
            begin
                unique case (out_func)
                    FN_NONE: pin_d = pin_q;
                    FN_LOW: pin_d = 1'b0;
                    FN_HIGH: pin_d = 1'b1;
                    FN_TOGGLE: pin_d = ~pin_q;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_q <= 1'b0;
        else
            pin_q <= pin_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_out_en <= 1'b0;
        else
            timer_out_en <= (mode_sel == MODE_CMP) || (mode_sel == MODE_PWM);
    end

    // pin leaves the block straight from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_out_pin <= 1'b0;
        else
            timer_out_pin <= pin_q ^ ((mode_sel == MODE_CMP) & out_invert);
    end
endmodule // periodic_timer

// file: periodic_timer_assertions.sv
// Purpose: port checker for the periodic timer
// Assumes: control registers are shadowed from APB writes
// Notes: calm means four cycles since the last control write
`timescale 1ns/1ps
module periodic_timer_assertions
    import ptm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire logic sub_clk_in,
    input wire logic timer_ext_clock_pin,
    input wire logic timer_out_pin,
    input wire logic timer_out_en,
    input wire logic match_a_irq,
    input wire logic match_b_irq
);
    // ********************
    // control shadow
    // ********************
    logic wr;
    logic clr_a;
    logic clr_b;
    logic calm;
    logic [7:0] c0_q;
    logic [7:0] c1_q;
    logic [2:0] calm_q;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
    assign clr_a = wr && apb_req.paddr == OFS_FLAGS && apb_req.pwdata[FL_A];
    assign clr_b = wr && apb_req.paddr == OFS_FLAGS && apb_req.pwdata[FL_B];
    assign calm = calm_q == 3'h4;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) c0_q <= 8'h00;
        else if (wr && apb_req.paddr == OFS_CTRL0) c0_q <= apb_req.pwdata[7:0];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) c1_q <= 8'h00;
        else if (wr && apb_req.paddr == OFS_CTRL1) c1_q <= apb_req.pwdata[7:0];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) calm_q <= 3'h0;
        else if (wr && apb_req.paddr inside {OFS_CTRL0, OFS_CTRL1}) calm_q <= 3'h0;
        else if (!calm) calm_q <= calm_q + 3'h1;
    // ********************
    // properties
    // ********************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
    sequence s_answer; apb_rsp.pready ##1 !apb_rsp.pready; endsequence
    property p_still(cond);
        calm && cond |-> !$rose(match_a_irq) && !$rose(match_b_irq);
    endproperty
    a_ready_once: assert property (s_setup |=> s_answer)
        else $error("pready not one cycle after setup");
    a_flag_a_keep: assert property ($fell(match_a_irq) |-> $past(clr_a))
        else $error("flag a dropped without clear");
    a_flag_b_keep: assert property ($fell(match_b_irq) |-> $past(clr_b))
        else $error("flag b dropped without clear");
    a_clrsel_no_b: assert property (calm && c1_q[C1_CLR] && c1_q[7] == c1_q[6]
        |-> !$rose(match_b_irq)) else $error("flag b raised with clear on a");
    a_tmr_pin_off: assert property (calm && c1_q[7:6] == MODE_TMR |-> !timer_out_en)
        else $error("pin driven in timer mode");
    a_nofn_pin_hold: assert property (calm && c1_q[7:4] == 4'h0 |-> $stable(timer_out_pin))
        else $error("pin moved with no output function");
    a_off_no_flag: assert property (p_still(!c0_q[C0_ON]))
        else $error("flag raised while off");
    a_pause_no_flag: assert property (p_still(c0_q[C0_PAUSE]))
        else $error("flag raised while paused");
endmodule // periodic_timer_assertions
bind periodic_timer periodic_timer_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .sub_clk_in(sub_clk_in),
    .timer_ext_clock_pin(timer_ext_clock_pin), .timer_out_pin(timer_out_pin),
    .timer_out_en(timer_out_en), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

// file: periodic_timer_tb.sv
// Purpose: self-checking bench for the periodic timer
// Assumes: APB answers after one access cycle
// Notes: sub clock is pclk/16, ext pin toggled by the bench
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module periodic_timer_tb
    import ptm_pkg::*;
;
    typedef struct packed { logic [7:0] a; logic [7:0] w; logic [7:0] e; } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    logic [3:0] sub_q = 4'h0;
    logic ext_q = 1'b0;
    logic pin, en, irq_a, irq_b, ini;
    logic [31:0] rdat, save;
    int fails = 0;
    int checks = 0;
    row_t rows [7] = '{'{OFS_CNT_LO, 8'hff, 8'h00}, '{OFS_CNT_HI, 8'hff, 8'h00},
        '{OFS_CMPA_LO, 8'ha5, 8'ha5}, '{OFS_CMPA_HI, 8'hff, 8'h03},
        '{OFS_PER_LO, 8'h5a, 8'h5a}, '{OFS_PER_HI, 8'hff, 8'h03}, '{8'h40, 8'hff, 8'h00}};
    periodic_timer u_periodic_timer (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .sub_clk_in(sub_q[3]), .timer_ext_clock_pin(ext_q),
        .timer_out_pin(pin), .timer_out_en(en), .match_a_irq(irq_a), .match_b_irq(irq_b));
    initial forever #2.5 pclk = ~pclk;
    always @(posedge pclk) sub_q <= sub_q + 4'h1;
    // ********************
    // bus and helper tasks
    // ********************
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{a, 1'b1, 1'b0, w, {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20) fails++;
        rdat = rsp.prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
        xfer(OFS_CTRL0, 1'b1, 8'h00);
        xfer(OFS_FLAGS, 1'b1, 8'h03);
        xfer(OFS_CTRL1, 1'b1, c1);
        xfer(OFS_CTRL0, 1'b1, c0);
    endtask
    task automatic cmp(input logic [9:0] a, input logic [9:0] b);
        xfer(OFS_CMPA_LO, 1'b1, a[7:0]);
        xfer(OFS_CMPA_HI, 1'b1, {6'h0, a[9:8]});
        xfer(OFS_PER_LO, 1'b1, b[7:0]);
        xfer(OFS_PER_HI, 1'b1, {6'h0, b[9:8]});
    endtask
    task automatic wait_irq(input logic b, input int lim);
        int n;
        n = 0;
        while ((b ? irq_b : irq_a) !== 1'b1 && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
    endtask
    task automatic pwm(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] b,
        input int win, input logic [10:0] e);
        logic [10:0] hi;
        hi = 11'h0;
        cmp(a, b);
        cfg(c1, 8'h18);
        repeat (20) @(negedge pclk);
        repeat (win)
        begin
            @(negedge pclk);
            hi = hi + {10'h0, pin};
        end
        `CHK(hi, e)
    endtask
    task automatic halt(input logic [7:0] c0);
        xfer(OFS_CTRL0, 1'b1, 8'h18);
        xfer(OFS_CTRL0, 1'b1, c0);
        repeat (4) @(negedge pclk);
        xfer(OFS_CNT_LO, 1'b0, 8'h00);
        save = rdat;
        repeat (20) @(negedge pclk);
        xfer(OFS_CNT_LO, 1'b0, 8'h00);
        `CHK(rdat, save)
    endtask
    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ********************
    // tests
    // ********************
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            xfer(rows[i].a, 1'b1, rows[i].w);
            xfer(rows[i].a, 1'b0, 8'h00);
            `CHK(rdat, {24'h0, rows[i].e})
            `CHK(rsp.pslverr, 1'b0)
        end
        $display("register table done");
        cmp(10'h2, 10'h4);
        for (int f = 1; f < 4; f++)
        begin
            ini = (f == 1);
            cfg({2'b00, 2'(f), ini, 3'b000}, 8'h38);
            repeat (3) @(negedge pclk);
            `CHK(pin, ini)
            `CHK(en, 1'b1)
            wait_irq(1'b0, 1000);
            repeat (2) @(negedge pclk);
            `CHK(pin, ~ini)
            wait_irq(1'b1, 1000);
            `CHK(irq_b, 1'b1)
        end
        cmp(10'h2, 10'h1);
        cfg(8'h01, 8'h38);
        wait_irq(1'b0, 1000);
        repeat (600) @(negedge pclk);
        `CHK(irq_b, 1'b0)
        `CHK(pin, 1'b0)
        cfg(8'hc1, 8'h38);
        wait_irq(1'b0, 1000);
        `CHK(irq_a, 1'b1)
        `CHK(en, 1'b0)
        $display("compare and timer modes done");
        pwm(8'ha8, 10'h2, 10'h8, 16, 11'h4);
        pwm(8'ha8, 10'h8, 10'h8, 16, 11'h10);
        pwm(8'hac, 10'h2, 10'h8, 16, 11'hc);
        pwm(8'ha0, 10'h2, 10'h8, 16, 11'hc);
        pwm(8'h98, 10'h2, 10'h8, 16, 11'h10);
        `CHK(irq_b & irq_a, 1'b1)
        pwm(8'ha8, 10'h200, 10'h0, 1024, 11'h200);
        $display("pwm done");
        cfg(8'h00, 8'h18);
        wait_irq(1'b1, 1100);
        `CHK(irq_b, 1'b1)
        halt(8'h98);
        halt(8'h58);
        halt(8'h10);
        xfer(OFS_CTRL0, 1'b1, 8'h58);
        xfer(OFS_CNT_LO, 1'b0, 8'h00);
        `CHK(rdat, 32'h0)
        $display("halt done");
        xfer(OFS_CTRL0, 1'b1, 8'h00);
        xfer(OFS_CTRL0, 1'b1, 8'h68);
        repeat (6)
        begin
            repeat (4) @(posedge pclk);
            ext_q <= ~ext_q;
        end
        repeat (4) @(posedge pclk);
        xfer(OFS_CNT_LO, 1'b0, 8'h00);
        `CHK(rdat, 32'h3)
        $display("external clock done");
        xfer(OFS_CTRL0, 1'b1, 8'h18);
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({pin, irq_a, irq_b}, 3'h0)
        foreach (rows[i])
        begin
            xfer(rows[i].a, 1'b0, 8'h00);
            `CHK(rdat, 32'h0)
        end
        $display("reset done");
        results();
    end
    initial
    begin
        #200000;
        fails++;
        results();
    end
endmodule // periodic_timer_tb
